// ==== rtl/capture_pkg.sv ====
// Shared constants for the input capture channel
package capture_pkg;

  // Data widths and buffer depth
  localparam int TIMER_W    = 16;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W      = 3;

  // Capture mode encodings
  localparam logic [2:0] MODE_OFF    = 3'h0;
  localparam logic [2:0] MODE_BOTH   = 3'h1;
  localparam logic [2:0] MODE_FALL   = 3'h2;
  localparam logic [2:0] MODE_RISE   = 3'h3;
  localparam logic [2:0] MODE_DIV4   = 3'h4;
  localparam logic [2:0] MODE_DIV16  = 3'h5;
  localparam logic [2:0] MODE_UNUSED = 3'h6;
  localparam logic [2:0] MODE_WAKE   = 3'h7;

  // Prescaler terminal counts (edges minus one)
  localparam int         PRE_W      = 4;
  localparam logic [3:0] PRE4_LAST  = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;

  // Interrupt count field: every event
  localparam logic [1:0] ICNT_EVERY = 2'h0;

  // Pin transition to capture event, in clock edges
  localparam int CAPTURE_LATENCY = 2;

  // Control word bit positions for read-back
  localparam int POS_MODE  = 0;
  localparam int POS_NE    = 3;
  localparam int POS_OV    = 4;
  localparam int POS_ICNT  = 5;
  localparam int POS_TSEL  = 7;
  localparam int POS_IDLE  = 13;
  localparam int CTRL_W    = 16;

endpackage : capture_pkg

// ==== rtl/edge_prescaler.sv ====
// Edge qualifier and 4:1 / 16:1 rising edge prescaler
`timescale 1ns/10ps
module edge_prescaler
  import capture_pkg::*;
(
  // Clock, reset, enable
  input  wire logic       ref_clk,
  input  wire logic       rstN,
  input  wire logic       clkEn,
  // Configuration
  input  wire logic [2:0] captureModeField,
  input  wire logic       clear,
  // Edge pulses from the pin pipeline
  input  wire logic       risePulse,
  input  wire logic       fallPulse,
  // Qualified capture event
  output logic            captureEvent
);

  logic [PRE_W-1:0] preCnt_ff;   // Rising edges seen so far
  logic [PRE_W-1:0] nxt_preCnt;  // Next count
  logic [PRE_W-1:0] lastCnt;     // Terminal count for this mode

  // Pick the event source by mode; divided modes count rising edges
  always_comb begin
    nxt_preCnt   = preCnt_ff;
    captureEvent = 1'b0;
    lastCnt      = (captureModeField == MODE_DIV4) ? PRE4_LAST : PRE16_LAST;
    case (captureModeField)
      MODE_BOTH: captureEvent = risePulse | fallPulse;
      MODE_FALL: captureEvent = fallPulse;
      MODE_RISE: captureEvent = risePulse;
      MODE_DIV4, MODE_DIV16: begin
        if (risePulse) begin
          if (preCnt_ff == lastCnt) begin
            captureEvent = 1'b1;
            nxt_preCnt   = '0;
          end else begin
            nxt_preCnt = preCnt_ff + 1'b1;
          end
        end
      end
      // Off, unused and wake modes make no captures
      default: captureEvent = 1'b0;
    endcase
    // Restart counting cleanly whenever the channel is off
    if (clear) begin
      nxt_preCnt = '0;
    end
  end

  // Prescaler register; frozen while the clock enable is low
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      preCnt_ff <= '0;
    end else if (clkEn) begin
      preCnt_ff <= nxt_preCnt;
    end
  end

endmodule : edge_prescaler

// ==== rtl/input_capture_fifo_channel.sv ====
// Input capture channel: edge qualifier, four deep FIFO, flags, interrupt
`timescale 1ns/10ps
// Overview of operation
// - Timebase select bit picks capture timer
// - Select 1 takes timebase a, 0 b
// - Each event stores full 16-bit timer
// - Modes: off, both, falling, rising edges
// - Modes capture every 4th, 16th rise
// - Wake mode: no captures, rising wake
// - Event two cycles after pin transition
// - Four deep FIFO, one write per event
// - Read returns oldest, others move forward
// - Disable or reset clears both flags
// - Not-empty sets on capture, clears drained
// - Overflow sets on event when full, no read
// - Overflow clears on fourth following read
// - Event while full, no read, stores nothing
// - Both-edges mode keeps overflow clear
// - Interrupt every 1st to 4th event
// - Overflow blocks interrupts unless count 00 or both-edges
// - Both-edges mode interrupts every event
// - Own irq flag with enable, priority
// - Idle halt bit stops channel in idle
module input_capture_fifo_channel
  import capture_pkg::*;
(
  // Clock, reset, clock enable
  input  wire logic               ref_clk,
  input  wire logic               nrst,
  input  wire logic               clkEn,
  // Control bits
  input  wire logic [2:0]         captureModeField,
  input  wire logic               timebaseSelect,
  input  wire logic [1:0]         irqCountField,
  input  wire logic               idleHaltBit,
  // Processor power state
  input  wire logic               cpuIdle,
  input  wire logic               cpuSleep,
  // Time bases and capture pin
  input  wire logic [TIMER_W-1:0] timebaseA,
  input  wire logic [TIMER_W-1:0] timebaseB,
  input  wire logic               captureInputPin,
  // FIFO read port
  input  wire logic               fifoReadStrobe,
  output logic [TIMER_W-1:0]      captureFifoPort,
  // Status
  output logic                    fifoNotEmptyFlag,
  output logic                    fifoOverrunFlag,
  output logic [CTRL_W-1:0]       captureControlWord,
  // Interrupt toward the system interrupt logic
  input  wire logic               captureIrqEnable,
  input  wire logic [2:0]         captureIrqPriority,
  input  wire logic               captureIrqClear,
  output logic                    captureIrqFlag,
  output logic                    captureIrqRequest,
  output logic [2:0]              captureIrqLevel
);

  // Reset release through two flops
  logic [1:0] rstPipe_ff;
  logic       rstN;

  // Pin pipeline and edges
  logic pinQ1_ff, pinQ2_ff;
  logic risePulse, fallPulse;

  // Channel condition
  logic disabled, halted, inWake, captureEvent, capEvt;
  logic [TIMER_W-1:0] selTime;

  // FIFO storage and occupancy
  logic [TIMER_W-1:0] fifoMem_ff [FIFO_DEPTH];
  logic [TIMER_W-1:0] nxt_fifoMem [FIFO_DEPTH];
  logic [CNT_W-1:0]   count_ff, nxt_count;
  logic               doRead, doWrite, isFull;

  // Flags and counters
  logic       ovFlag_ff, nxt_ovFlag, ovSet;
  logic [2:0] ovReads_ff, nxt_ovReads;
  logic [1:0] evCnt_ff, nxt_evCnt;
  logic       irqSet, wakeSet;
  logic       irqFlag_ff, nxt_irqFlag;
  logic [2:0] irqLevel_ff, nxt_irqLevel;

  // Reset synchroniser runs regardless of the clock enable
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rstPipe_ff <= 2'h0;
    end else begin
      rstPipe_ff <= {rstPipe_ff[0], 1'b1};
    end
  end
  assign rstN = rstPipe_ff[1];

  // Pin is synchronous; one stage plus compare gives the fixed latency
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      pinQ1_ff <= 1'b0;
      pinQ2_ff <= 1'b0;
    end else if (clkEn) begin
      pinQ1_ff <= captureInputPin;
      pinQ2_ff <= pinQ1_ff;
    end
  end

  // Edge detection and halt qualification
  always_comb begin
    risePulse = pinQ1_ff & ~pinQ2_ff;
    fallPulse = ~pinQ1_ff & pinQ2_ff;
    disabled  = (captureModeField == MODE_OFF) || (captureModeField == MODE_UNUSED);
    inWake    = (captureModeField == MODE_WAKE);
    // Sleep always stops capture; idle only when asked to
    halted    = cpuSleep | (cpuIdle & idleHaltBit);
    capEvt    = captureEvent & ~halted & ~disabled;
    // Timer mux; select high takes the first timer
    selTime   = timebaseSelect ? timebaseA : timebaseB;
  end

  // Edge qualification and prescaling live in the child
  edge_prescaler u_prescaler (
    .ref_clk          (ref_clk),
    .rstN             (rstN),
    .clkEn            (clkEn),
    .captureModeField (captureModeField),
    .clear            (disabled),
    .risePulse        (risePulse & ~halted),
    .fallPulse        (fallPulse & ~halted),
    .captureEvent     (captureEvent)
  );

  // FIFO next state: read shifts toward the head, write lands behind
  always_comb begin
    isFull  = (count_ff == CNT_W'(FIFO_DEPTH));
    doRead  = fifoReadStrobe && (count_ff != '0);
    // A read in the same cycle frees a slot, so a full FIFO still takes it
    doWrite = capEvt && (!isFull || doRead);
    nxt_count = count_ff;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      nxt_fifoMem[i] = fifoMem_ff[i];
    end
    if (doRead) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        nxt_fifoMem[i] = fifoMem_ff[i+1];
      end
      nxt_count = count_ff - 1'b1;
    end
    if (doWrite) begin
      nxt_fifoMem[nxt_count[1:0]] = selTime;
      nxt_count = nxt_count + 1'b1;
    end
    // Disabling the channel drains the buffer
    if (disabled) begin
      nxt_count = '0;
    end
  end

  // FIFO registers; reset clears both data and occupancy
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      count_ff <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifoMem_ff[i] <= '0;
      end
    end else if (clkEn) begin
      count_ff   <= nxt_count;
      fifoMem_ff <= nxt_fifoMem;
    end
  end

  // Overflow and interrupt counting
  always_comb begin
    // Overflow never flags in both-edges mode
    ovSet = capEvt && isFull && !doRead &&
            (captureModeField != MODE_BOTH);
    nxt_ovFlag  = ovFlag_ff;
    nxt_ovReads = ovReads_ff;
    if (ovFlag_ff && doRead) begin
      if (ovReads_ff == 3'(FIFO_DEPTH - 1)) begin
        nxt_ovFlag  = 1'b0;
        nxt_ovReads = '0;
      end else begin
        nxt_ovReads = ovReads_ff + 1'b1;
      end
    end
    // A read in the same cycle blocks the set; the fourth read still clears
    if (ovSet) begin
      nxt_ovFlag = 1'b1;
      if (!ovFlag_ff) begin
        nxt_ovReads = '0;
      end
    end
    // Interrupt: every event in both-edges mode or count 00
    irqSet    = 1'b0;
    nxt_evCnt = evCnt_ff;
    if (capEvt) begin
      if (captureModeField == MODE_BOTH || irqCountField == ICNT_EVERY) begin
        irqSet = 1'b1;
      end else if (evCnt_ff == irqCountField) begin
        nxt_evCnt = '0;
        // Pending overflow withholds the grouped interrupt
        irqSet = !(ovFlag_ff || ovSet);
      end else begin
        nxt_evCnt = evCnt_ff + 1'b1;
      end
    end
    // Wake mode: a rising edge while asleep or idle raises the flag
    wakeSet = inWake && risePulse && (cpuSleep || cpuIdle);
    if (disabled) begin
      nxt_ovFlag  = 1'b0;
      nxt_ovReads = '0;
      nxt_evCnt   = '0;
    end
    // Sticky request flag; a new event wins over the clear
    nxt_irqFlag = (irqFlag_ff && !captureIrqClear) || irqSet || wakeSet;
    nxt_irqLevel = (nxt_irqFlag && captureIrqEnable) ? captureIrqPriority : 3'h0;
  end

  // Flag and counter registers
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      ovFlag_ff   <= 1'b0;
      ovReads_ff  <= '0;
      evCnt_ff    <= '0;
      irqFlag_ff  <= 1'b0;
      irqLevel_ff <= 3'h0;
    end else if (clkEn) begin
      ovFlag_ff   <= nxt_ovFlag;
      ovReads_ff  <= nxt_ovReads;
      evCnt_ff    <= nxt_evCnt;
      irqFlag_ff  <= nxt_irqFlag;
      irqLevel_ff <= nxt_irqLevel;
    end
  end

  // Outputs; head entry and flags all come from flops
  always_comb begin
    captureFifoPort   = fifoMem_ff[0];
    fifoNotEmptyFlag  = (count_ff != '0);
    fifoOverrunFlag   = ovFlag_ff;
    captureIrqFlag    = irqFlag_ff;
    captureIrqRequest = irqFlag_ff & captureIrqEnable;
    captureIrqLevel   = irqLevel_ff;
    captureControlWord = '0;
    captureControlWord[POS_MODE +: 3] = captureModeField;
    captureControlWord[POS_NE]        = fifoNotEmptyFlag;
    captureControlWord[POS_OV]        = ovFlag_ff;
    captureControlWord[POS_ICNT +: 2] = irqCountField;
    captureControlWord[POS_TSEL]      = timebaseSelect;
    captureControlWord[POS_IDLE]      = idleHaltBit;
  end

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  AST_LATENCY: assert property (
    ($rose(captureInputPin) && clkEn && captureModeField == MODE_RISE && !halted)
    ##1 (clkEn && $stable(captureModeField) && !halted) |-> capEvt)
    else $error("Rising edge did not give a capture event");
  AST_NO_CAPTURE_OFF: assert property (disabled || inWake |-> !capEvt)
    else $error("Capture event in a mode that captures nothing");
  AST_STORE_VALUE: assert property (
    clkEn && capEvt && !doRead && !isFull && !disabled |=>
    fifoMem_ff[$past(count_ff[1:0])] == $past(selTime) && count_ff == $past(count_ff) + 1'b1)
    else $error("Captured timer value not stored");
  AST_FULL_HOLD: assert property (
    clkEn && capEvt && isFull && !doRead |=> $stable(fifoMem_ff[3]) && isFull)
    else $error("Full FIFO changed on capture");
  AST_OV_SET: assert property (
    clkEn && capEvt && isFull && !doRead && captureModeField != MODE_BOTH |=> ovFlag_ff)
    else $error("Overflow flag not set");
  AST_OV_BOTH: assert property (
    captureModeField == MODE_BOTH && $past(captureModeField) == MODE_BOTH
    && $past(ovFlag_ff) == 1'b0 |-> !ovFlag_ff)
    else $error("Overflow set in both-edges mode");
  AST_CLEAR_OFF: assert property (
    clkEn && disabled |=> !fifoNotEmptyFlag && !fifoOverrunFlag && evCnt_ff == 2'h0)
    else $error("Flags not cleared while disabled");
  AST_NE_SET: assert property (clkEn && capEvt |=> fifoNotEmptyFlag)
    else $error("Not-empty flag missing after capture");
  AST_IRQ_BOTH: assert property (
    clkEn && capEvt && captureModeField == MODE_BOTH |=> captureIrqFlag)
    else $error("No interrupt on both-edges capture");
  AST_IRQ_BLOCK: assert property (
    ovFlag_ff && irqCountField != ICNT_EVERY && captureModeField != MODE_BOTH
    |-> !irqSet)
    else $error("Grouped interrupt raised during overflow");
  AST_OV_CLEAR: assert property (
    clkEn && ovFlag_ff && doRead && ovReads_ff == 3'h3 && !ovSet |=> !ovFlag_ff)
    else $error("Overflow not cleared on fourth read");

  COV_OVERFLOW: cover property (ovSet);
  COV_IRQ_FOURTH: cover property (irqSet && irqCountField == 2'h3);
  COV_DIV16: cover property (capEvt && captureModeField == MODE_DIV16);
  COV_WAKE: cover property (wakeSet);

endmodule : input_capture_fifo_channel

// ==== verif/pin_source.sv ====
// Behavioural source driving the capture input pin
`timescale 1ns/10ps
module pin_source (
  // Clock and toggle request
  input  wire logic ref_clk,
  input  wire logic toggleReq,
  // Pin level seen by the channel
  output logic      pinLevel_ff
);
  // Pin idles low, so the first toggle is a rising edge
  initial pinLevel_ff = 1'b0;

  // Flip the pin on the edge after a request; the bench spaces requests
  // at least four cycles apart so each level outlives the minimum hold
  always @(posedge ref_clk) begin
    if (toggleReq) begin
      pinLevel_ff <= ~pinLevel_ff;
    end
  end
endmodule : pin_source

// ==== verif/input_capture_fifo_channel_tb.sv ====
// Self-checking bench for the input capture channel
`timescale 1ns/10ps
module input_capture_fifo_channel_tb;
  import capture_pkg::*;
  // Clock, reset and control bits
  logic               ref_clk            = 1'b0;
  logic               nrst               = 1'b0;
  logic               clkEn              = 1'b1;
  logic [2:0]         captureModeField   = MODE_OFF;
  logic               timebaseSelect     = 1'b1;
  logic [1:0]         irqCountField      = 2'h0;
  logic               idleHaltBit        = 1'b0;
  logic               cpuIdle            = 1'b0;
  logic               cpuSleep           = 1'b0;
  // Time bases, pin and read port
  logic [TIMER_W-1:0] timebaseA          = 16'h0;
  logic [TIMER_W-1:0] timebaseB          = 16'h0;
  logic               captureInputPin;
  logic               fifoReadStrobe     = 1'b0;
  logic [TIMER_W-1:0] captureFifoPort;
  // Status and interrupt
  logic               fifoNotEmptyFlag;
  logic               fifoOverrunFlag;
  logic [CTRL_W-1:0]  captureControlWord;
  logic               captureIrqEnable   = 1'b1;
  logic [2:0]         captureIrqPriority = 3'h5;
  logic               captureIrqClear    = 1'b0;
  logic               captureIrqFlag;
  logic               captureIrqRequest;
  logic [2:0]         captureIrqLevel;
  // Partner request and score keeping
  logic               toggleReq          = 1'b0;
  int                 mismatches         = 0;
  int                 comparisons        = 0;
  int                 n;

  // Free running clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  input_capture_fifo_channel i_dut (
    .ref_clk, .nrst, .clkEn, .captureModeField, .timebaseSelect, .irqCountField,
    .idleHaltBit, .cpuIdle, .cpuSleep, .timebaseA, .timebaseB, .captureInputPin,
    .fifoReadStrobe, .captureFifoPort, .fifoNotEmptyFlag, .fifoOverrunFlag,
    .captureControlWord, .captureIrqEnable, .captureIrqPriority, .captureIrqClear,
    .captureIrqFlag, .captureIrqRequest, .captureIrqLevel);

  pin_source i_pin (.ref_clk, .toggleReq, .pinLevel_ff(captureInputPin));

  // Compare one value, count it, report a mismatch at once
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One pin transition; timer values stay put until the capture lands
  task automatic flip(input logic [15:0] v);
    timebaseA <= v;
    timebaseB <= ~v;
    toggleReq <= 1'b1;
    @(posedge ref_clk);
    toggleReq <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask : flip

  // Rising edge carrying v, then a falling edge carrying v with msb flipped
  task automatic pulse(input logic [15:0] v);
    flip(v);
    flip(v ^ 16'h8000);
  endtask : pulse

  // Reconfigure only through the off mode
  task automatic set_mode(input logic [2:0] m, input logic ts, input logic [1:0] ic);
    captureModeField <= MODE_OFF;
    @(posedge ref_clk);
    timebaseSelect   <= ts;
    irqCountField    <= ic;
    @(posedge ref_clk);
    captureModeField <= m;
    repeat (2) @(posedge ref_clk);
  endtask : set_mode

  // Check the oldest word, then pop it
  task automatic rd(input logic [15:0] exp);
    chk("fifo word", captureFifoPort, exp);
    fifoReadStrobe <= 1'b1;
    @(posedge ref_clk);
    fifoReadStrobe <= 1'b0;
    @(posedge ref_clk);
  endtask : rd

  // Drop the sticky interrupt flag
  task automatic irq_clr;
    captureIrqClear <= 1'b1;
    @(posedge ref_clk);
    captureIrqClear <= 1'b0;
    @(posedge ref_clk);
  endtask : irq_clr

  // Print counts and the verdict, then stop
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : test_done

  // Main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk("ne after reset", 16'(fifoNotEmptyFlag), 16'h0);
    chk("ov after reset", 16'(fifoOverrunFlag), 16'h0);
    // Rising mode on timebase a: latency, fill, overflow, drain
    set_mode(MODE_RISE, 1'b1, 2'h0);
    timebaseA <= 16'h1000;
    timebaseB <= 16'hefff;
    toggleReq <= 1'b1;
    @(posedge ref_clk);
    toggleReq <= 1'b0;
    // Look mid-cycle so the edge that writes the entry has settled
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk("ne early", 16'(fifoNotEmptyFlag), 16'h0);
    @(negedge ref_clk);
    chk("ne on time", 16'(fifoNotEmptyFlag), 16'h1);
    @(posedge ref_clk);
    flip(16'h9000);
    for (int i = 1; i < 5; i++) pulse(16'h1000 + 16'(i));
    chk("ov on fifth", 16'(fifoOverrunFlag), 16'h1);
    irq_clr();
    pulse(16'h1005);
    chk("irq count 00 on overflow", 16'(captureIrqFlag), 16'h1);
    // A read strobe while the clock enable is low must not pop
    clkEn <= 1'b0;
    rd(16'h1000);
    clkEn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (i == 3) chk("ov before 4th read", 16'(fifoOverrunFlag), 16'h1);
      rd(16'h1000 + 16'(i));
    end
    chk("ov after 4 reads", 16'(fifoOverrunFlag), 16'h0);
    chk("ne drained", 16'(fifoNotEmptyFlag), 16'h0);
    // Falling mode on timebase b, one word read, one left, then disabled
    set_mode(MODE_FALL, 1'b0, 2'h0);
    pulse(16'h2000);
    pulse(16'h2001);
    rd(~16'ha000);
    chk("ne one left", 16'(fifoNotEmptyFlag), 16'h1);
    // Both edges: every edge interrupts, full fifo never overflows
    set_mode(MODE_BOTH, 1'b1, 2'h3);
    chk("ne cleared by disable", 16'(fifoNotEmptyFlag), 16'h0);
    irq_clr();
    flip(16'h3000);
    chk("irq both edges", 16'(captureIrqFlag), 16'h1);
    for (int i = 1; i < 6; i++) flip(16'h3000 + 16'(i));
    chk("ov both edges", 16'(fifoOverrunFlag), 16'h0);
    for (int i = 0; i < 4; i++) rd(16'h3000 + 16'(i));
    // Prescaled modes: capture on the 4th and 16th rise only
    for (int j = 0; j < 2; j++) begin
      n = j ? 16 : 4;
      set_mode(j ? MODE_DIV16 : MODE_DIV4, 1'b1, 2'h0);
      for (int i = 1; i <= n; i++) begin
        if (i == n) chk("ne before last rise", 16'(fifoNotEmptyFlag), 16'h0);
        pulse(16'h4000 + 16'(i));
      end
      rd(16'h4000 + 16'(n));
    end
    // Interrupt after 1st..4th capture, with read-back of the control word
    for (int c = 0; c < 4; c++) begin
      set_mode(MODE_RISE, 1'b1, 2'(c));
      irq_clr();
      chk("ctrl word", captureControlWord, {8'h0, 1'b1, 2'(c), 2'h0, MODE_RISE});
      for (int i = 0; i <= c; i++) begin
        if (i == c) chk("irq early", 16'(captureIrqFlag), 16'h0);
        pulse(16'h5000 + 16'(i));
      end
      chk("irq on count", 16'(captureIrqFlag), 16'h1);
      // Handler drains every stored value; last round stays full for overflow
      if (c != 3) for (int i = 0; i <= c; i++) rd(16'h5000 + 16'(i));
    end
    irq_clr();
    repeat (4) pulse(16'h5100);
    chk("irq blocked by overflow", 16'(captureIrqFlag), 16'h0);
    // Idle halt then resume
    idleHaltBit <= 1'b1;
    cpuIdle     <= 1'b1;
    set_mode(MODE_RISE, 1'b1, 2'h0);
    pulse(16'h6000);
    chk("ne while halted", 16'(fifoNotEmptyFlag), 16'h0);
    set_mode(MODE_OFF, 1'b1, 2'h0);
    idleHaltBit <= 1'b0;
    set_mode(MODE_RISE, 1'b1, 2'h0);
    pulse(16'h6001);
    chk("ne idle running", 16'(fifoNotEmptyFlag), 16'h1);
    // The unused mode captures nothing even with the channel running
    set_mode(MODE_UNUSED, 1'b1, 2'h0);
    pulse(16'h6002);
    chk("ne unused mode", 16'(fifoNotEmptyFlag), 16'h0);
    // Wake mode in sleep: interrupt only, no capture
    cpuIdle  <= 1'b0;
    cpuSleep <= 1'b1;
    set_mode(MODE_WAKE, 1'b1, 2'h0);
    irq_clr();
    pulse(16'h7000);
    chk("irq wake", 16'(captureIrqFlag), 16'h1);
    chk("ne wake", 16'(fifoNotEmptyFlag), 16'h0);
    chk("irq request", 16'(captureIrqRequest), 16'h1);
    chk("irq level", 16'(captureIrqLevel), 16'h5);
    captureIrqEnable <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("irq request masked", 16'(captureIrqRequest), 16'h0);
    chk("irq level masked", 16'(captureIrqLevel), 16'h0);
    test_done();
  end

  // Watchdog: the sequence needs about 620 cycles
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end
endmodule : input_capture_fifo_channel_tb
